/* rtl/ptg_pins.sv */
`timescale 1ns/100ps
module ptg_pins (
    // clock and reset
    input  wire logic                                 sys_clk,
    input  wire logic                                 rst_b,
    // apb slave
    input  wire logic [ptg_pkg::ADDR_W-1:0]           paddr,
    input  wire logic                                 psel,
    input  wire logic                                 penable,
    input  wire logic                                 pwrite,
    input  wire logic [ptg_pkg::DATA_W-1:0]           pwdata,
    output logic      [ptg_pkg::DATA_W-1:0]           prdata,
    output logic                                      pready,
    output logic                                      pslverr,
    // trigger pins
    input  wire logic                                 pattern_advance_in,
    input  wire logic                                 pattern_start_stop_in,
    output logic                                      exposure_active_out,
    output logic                                      first_pattern_out,
    // sequencing interrupt loop
    output logic                                      seq_irq_loop_out,
    input  wire logic                                 seq_irq_loop_in,
    // dual-controller pins
    output logic                                      split_data_cfg_out,
    input  wire logic                                 ctrl_role_in,
    // general-purpose pins
    input  wire logic [ptg_pkg::NUM_GPIO-1:0]         gpio_in,
    output logic      [ptg_pkg::NUM_GPIO-1:0]         gpio_out,
    output logic      [ptg_pkg::NUM_GPIO-1:0]         gpio_oe
);

    localparam int NG = ptg_pkg::NUM_GPIO;
    localparam int NP = ptg_pkg::NUM_PWM;

    // software registers
    logic [ptg_pkg::DATA_W-1:0]      ctrl;
    logic [ptg_pkg::DATA_W-1:0]      seq_cfg;
    logic [NG*ptg_pkg::MODE_W-1:0]   gpio_mode;
    logic [NG-1:0]                   gpio_val;
    logic [NG-1:0]                   gpio_drv;
    logic [NP-1:0]                   pwm_sel;
    ptg_pkg::ptg_pwm_cfg_s           pwm_cfg [NP];

    // synchronised inputs
    logic [ptg_pkg::SYNC_W-1:0]      sy1;
    logic [ptg_pkg::SYNC_W-1:0]      sy2;
    logic [ptg_pkg::SYNC_W-1:0]      sy3;
    logic [ptg_pkg::SYNC_W-1:0]      clean;
    logic [ptg_pkg::SYNC_W-1:0]      clean_d;

    // sequencer
    ptg_pkg::ptg_state_e             state;
    ptg_pkg::ptg_state_e             next_state;
    logic                            running;
    logic [ptg_pkg::IDX_W-1:0]       idx;
    logic [ptg_pkg::CNT_W-1:0]       exp_cnt;
    logic [NP-1:0]                   pwm_wave;

    // decoded events
    logic                            primary;
    logic                            video_mode;
    logic                            adv_rise;
    logic                            ss_rise;
    logic                            ss_fall;
    logic                            loop_rise;
    logic                            wr_en;
    logic                            rd_setup;
    logic                            sw_start;
    logic                            sw_stop;
    logic                            last_idx;
    logic [ptg_pkg::IDX_W-1:0]       pat_count;
    logic [ptg_pkg::CNT_W-1:0]       exp_len;
    logic [ptg_pkg::DATA_W-1:0]      rd_word;
    logic                            rd_hit;
    logic [ptg_pkg::SYNC_W-1:0]      raw_in;

    // ---------------- input synchronisers
    assign raw_in = {gpio_in, ctrl_role_in, seq_irq_loop_in,
                     pattern_start_stop_in, pattern_advance_in};

    // a change is accepted only once stages two and three agree
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            sy1     <= '0;
            sy2     <= '0;
            sy3     <= '0;
            clean   <= '0;
            clean_d <= '0;
        end else begin
            sy1     <= raw_in;
            sy2     <= sy1;
            sy3     <= sy2;
            clean   <= (sy2 & sy3) | (clean & (sy2 ^ sy3));
            clean_d <= clean;
        end
    end

    // role is held secondary until the synchronised pin says otherwise
    assign primary    = clean[ptg_pkg::SY_ROLE];
    assign video_mode = ctrl[ptg_pkg::CTRL_MODE_BIT] & primary;
    assign adv_rise   = clean[ptg_pkg::SY_ADV] & ~clean_d[ptg_pkg::SY_ADV];
    assign ss_rise    = clean[ptg_pkg::SY_SS] & ~clean_d[ptg_pkg::SY_SS];
    assign ss_fall    = ~clean[ptg_pkg::SY_SS] & clean_d[ptg_pkg::SY_SS];
    assign loop_rise  = clean[ptg_pkg::SY_LOOP] & ~clean_d[ptg_pkg::SY_LOOP];

    // ---------------- apb slave, zero wait states
    assign pready   = 1'b1;
    assign wr_en    = psel & penable & pwrite;
    assign rd_setup = psel & ~penable & ~pwrite;
    assign sw_start = wr_en && (paddr == ptg_pkg::REG_CMD) && pwdata[ptg_pkg::CMD_START_BIT];
    assign sw_stop  = wr_en && (paddr == ptg_pkg::REG_CMD) && pwdata[ptg_pkg::CMD_STOP_BIT];

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            ctrl      <= ptg_pkg::CTRL_RST;
            seq_cfg   <= ptg_pkg::SEQ_RST;
            gpio_mode <= '0;
            gpio_val  <= '0;
            gpio_drv  <= '0;
            pwm_sel   <= '0;
        end else if (wr_en) begin
            case (paddr)
                ptg_pkg::REG_CTRL:      ctrl      <= pwdata;
                ptg_pkg::REG_SEQ:       seq_cfg   <= pwdata;
                ptg_pkg::REG_GPIO_MODE: gpio_mode <= pwdata[NG*ptg_pkg::MODE_W-1:0];
                ptg_pkg::REG_GPIO_OUT: begin
                    gpio_val <= pwdata[NG-1:0];
                    gpio_drv <= pwdata[ptg_pkg::GPIO_OE_LSB +: NG];
                end
                ptg_pkg::REG_PWM_SEL:   pwm_sel   <= pwdata[NP-1:0];
                default: ;
            endcase
        end
    end

    genvar gc;
    generate
        for (gc = 0; gc < NP; gc++) begin : g_cfg
            localparam logic [ptg_pkg::ADDR_W-1:0] CFG_ADDR =
                ptg_pkg::ADDR_W'(ptg_pkg::REG_PWM_CFG0 + gc * ptg_pkg::REG_PWM_STEP);
            always_ff @(posedge sys_clk) begin
                if (!rst_b) begin
                    pwm_cfg[gc] <= '0;
                end else if (wr_en && paddr == CFG_ADDR) begin
                    pwm_cfg[gc] <= pwdata;
                end
            end
        end
    endgenerate

    always_comb begin
        rd_word = '0;
        rd_hit  = 1'b1;
        case (paddr)
            ptg_pkg::REG_CTRL:      rd_word = ctrl;
            ptg_pkg::REG_CMD:       rd_word = '0;
            ptg_pkg::REG_SEQ:       rd_word = seq_cfg;
            ptg_pkg::REG_STATUS: begin
                rd_word[ptg_pkg::STAT_RUN_BIT]          = running;
                rd_word[ptg_pkg::STAT_PRIM_BIT]         = primary;
                rd_word[ptg_pkg::STAT_STATE_LSB +: 2]   = state;
                rd_word[ptg_pkg::STAT_IDX_LSB +: ptg_pkg::IDX_W] = idx;
            end
            ptg_pkg::REG_GPIO_MODE: rd_word[NG*ptg_pkg::MODE_W-1:0] = gpio_mode;
            ptg_pkg::REG_GPIO_OUT: begin
                rd_word[NG-1:0]                     = gpio_val;
                rd_word[ptg_pkg::GPIO_OE_LSB +: NG] = gpio_drv;
            end
            ptg_pkg::REG_GPIO_IN:   rd_word[NG-1:0] = clean[ptg_pkg::SY_GPIO +: NG];
            ptg_pkg::REG_PWM_SEL:   rd_word[NP-1:0] = pwm_sel;
            default: begin
                rd_hit = 1'b0;
                for (int k = 0; k < NP; k++) begin
                    if (paddr == ptg_pkg::ADDR_W'(ptg_pkg::REG_PWM_CFG0
                                                  + k * ptg_pkg::REG_PWM_STEP)) begin
                        rd_word = pwm_cfg[k];
                        rd_hit  = 1'b1;
                    end
                end
            end
        endcase
    end

    // read data and error are caught in the setup cycle so the access phase sees flops
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            prdata  <= '0;
            pslverr <= 1'b0;
        end else if (psel & ~penable) begin
            prdata  <= rd_setup ? rd_word : '0;
            pslverr <= ~rd_hit;
        end
    end

    // ---------------- run control
    // trigger and software are merged: either source can start, either can stop;
    // a start landing together with a stop wins so that no start is dropped
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            running <= 1'b0;
        end else if (!video_mode) begin
            running <= 1'b0;
        end else if (ss_rise | sw_start) begin
            running <= 1'b1;
        end else if (ss_fall | sw_stop) begin
            running <= 1'b0;
        end
    end

    // ---------------- pattern sequencer
    assign pat_count = seq_cfg[ptg_pkg::SEQ_CNT_LSB +: ptg_pkg::IDX_W];
    assign exp_len   = seq_cfg[ptg_pkg::SEQ_EXP_LSB +: ptg_pkg::CNT_W];
    assign last_idx  = (pat_count <= 8'h01) || (idx >= pat_count - 8'h01);

    always_comb begin
        next_state = state;
        case (state)
            ptg_pkg::ST_IDLE:
                if (running) next_state = ptg_pkg::ST_EXPOSE;
            ptg_pkg::ST_EXPOSE:
                if (exp_cnt <= 16'h0001) next_state = ptg_pkg::ST_IRQ;
            // the step happens only once the interrupt has come back on the loop input
            ptg_pkg::ST_IRQ:
                if (loop_rise) next_state = ptg_pkg::ST_ADVANCE;
            ptg_pkg::ST_ADVANCE:
                if (!running) next_state = ptg_pkg::ST_IDLE;
                else if (adv_rise | ctrl[ptg_pkg::CTRL_AUTO_BIT])
                    next_state = ptg_pkg::ST_EXPOSE;
            default: next_state = ptg_pkg::ST_IDLE;
        endcase
        if (!video_mode) next_state = ptg_pkg::ST_IDLE;
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            state <= ptg_pkg::ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // index restarts at the first pattern on a start from idle; a restart before idle is reached keeps the index
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            idx <= '0;
        end else if (state == ptg_pkg::ST_IDLE) begin
            idx <= '0;
        end else if (state == ptg_pkg::ST_IRQ && loop_rise) begin
            idx <= last_idx ? '0 : idx + 8'h01;
        end
    end

    // a zero exposure length still gives one cycle of exposure
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            exp_cnt <= '0;
        end else if (next_state == ptg_pkg::ST_EXPOSE && state != ptg_pkg::ST_EXPOSE) begin
            exp_cnt <= exp_len;
        end else if (state == ptg_pkg::ST_EXPOSE && exp_cnt != '0) begin
            exp_cnt <= exp_cnt - 16'h0001;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            exposure_active_out <= 1'b0;
            first_pattern_out   <= 1'b0;
            seq_irq_loop_out    <= 1'b0;
        end else begin
            exposure_active_out <= (next_state == ptg_pkg::ST_EXPOSE);
            first_pattern_out   <= (next_state == ptg_pkg::ST_EXPOSE) &&
                                   (idx == '0);
            seq_irq_loop_out    <= (next_state == ptg_pkg::ST_IRQ);
        end
    end

    // the split request falls when the role pin says secondary
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            split_data_cfg_out <= 1'b1;
        end else begin
            split_data_cfg_out <= ctrl[ptg_pkg::CTRL_SPLIT_BIT] & primary;
        end
    end

    // ---------------- pwm generators
    genvar gp;
    generate
        for (gp = 0; gp < NP; gp++) begin : g_pwm
            logic [ptg_pkg::CNT_W-1:0] cnt;
            always_ff @(posedge sys_clk) begin
                if (!rst_b) begin
                    cnt          <= '0;
                    pwm_wave[gp] <= 1'b0;
                end else if (!pwm_sel[gp] || !primary) begin
                    cnt          <= '0;
                    pwm_wave[gp] <= 1'b0;
                end else begin
                    cnt          <= (cnt >= pwm_cfg[gp].period) ? '0 : cnt + 16'h0001;
                    pwm_wave[gp] <= (cnt < pwm_cfg[gp].duty);
                end
            end
        end
    endgenerate

    // ---------------- general-purpose pins
    genvar gi;
    generate
        for (gi = 0; gi < NG; gi++) begin : g_gpio
            ptg_pkg::ptg_gpio_mode_e mode;
            logic                    val;
            assign mode = ptg_pkg::ptg_gpio_mode_e'(gpio_mode[gi*ptg_pkg::MODE_W +:
                                                              ptg_pkg::MODE_W]);
            if (gi < NP) begin : g_alt
                assign val = pwm_sel[gi] ? pwm_wave[gi] : gpio_val[gi];
            end else begin : g_plain
                assign val = gpio_val[gi];
            end
            always_ff @(posedge sys_clk) begin
                if (!rst_b) begin
                    gpio_out[gi] <= 1'b0;
                    gpio_oe[gi]  <= 1'b0;
                end else if (!primary) begin
                    gpio_out[gi] <= 1'b0;
                    gpio_oe[gi]  <= 1'b0;
                end else begin
                    case (mode)
                        ptg_pkg::GM_OUTPUT: begin
                            gpio_out[gi] <= val;
                            gpio_oe[gi]  <= 1'b1;
                        end
                        ptg_pkg::GM_BIDIR: begin
                            gpio_out[gi] <= val;
                            gpio_oe[gi]  <= gpio_drv[gi];
                        end
                        // open-drain only ever pulls low; the pull-up gives the high
                        ptg_pkg::GM_OPEN_DRAIN: begin
                            gpio_out[gi] <= 1'b0;
                            gpio_oe[gi]  <= ~val;
                        end
                        default: begin
                            gpio_out[gi] <= 1'b0;
                            gpio_oe[gi]  <= 1'b0;
                        end
                    endcase
                end
            end
        end
    endgenerate

endmodule : ptg_pins

/* rtl/ptg_pkg.sv */
package ptg_pkg;

    // widths and counts
    localparam int ADDR_W   = 8;
    localparam int DATA_W   = 32;
    localparam int NUM_GPIO = 9;
    localparam int NUM_PWM  = 4;
    localparam int MODE_W   = 2;
    localparam int IDX_W    = 8;
    localparam int CNT_W    = 16;
    localparam int SYNC_W   = 4 + NUM_GPIO;

    // register byte offsets
    localparam logic [ADDR_W-1:0] REG_CTRL      = 8'h00;
    localparam logic [ADDR_W-1:0] REG_CMD       = 8'h04;
    localparam logic [ADDR_W-1:0] REG_SEQ       = 8'h08;
    localparam logic [ADDR_W-1:0] REG_STATUS    = 8'h0C;
    localparam logic [ADDR_W-1:0] REG_GPIO_MODE = 8'h10;
    localparam logic [ADDR_W-1:0] REG_GPIO_OUT  = 8'h14;
    localparam logic [ADDR_W-1:0] REG_GPIO_IN   = 8'h18;
    localparam logic [ADDR_W-1:0] REG_PWM_SEL   = 8'h1C;
    localparam logic [ADDR_W-1:0] REG_PWM_CFG0  = 8'h20;
    localparam logic [ADDR_W-1:0] REG_PWM_STEP  = 8'h04;

    // field positions
    localparam int CTRL_MODE_BIT  = 0;
    localparam int CTRL_AUTO_BIT  = 1;
    localparam int CTRL_SPLIT_BIT = 2;
    localparam int CMD_START_BIT  = 0;
    localparam int CMD_STOP_BIT   = 1;
    localparam int SEQ_CNT_LSB    = 0;
    localparam int SEQ_EXP_LSB    = 16;
    localparam int STAT_RUN_BIT   = 0;
    localparam int STAT_PRIM_BIT  = 1;
    localparam int STAT_STATE_LSB = 2;
    localparam int STAT_IDX_LSB   = 8;
    localparam int GPIO_OE_LSB    = 16;

    // synchroniser lanes
    localparam int SY_ADV  = 0;
    localparam int SY_SS   = 1;
    localparam int SY_LOOP = 2;
    localparam int SY_ROLE = 3;
    localparam int SY_GPIO = 4;

    // reset values
    localparam logic [DATA_W-1:0] CTRL_RST = 32'h0000_0004;
    localparam logic [DATA_W-1:0] SEQ_RST  = 32'h0001_0001;

    typedef enum logic [1:0] {
        GM_INPUT      = 2'h0,
        GM_OUTPUT     = 2'h1,
        GM_BIDIR      = 2'h2,
        GM_OPEN_DRAIN = 2'h3
    } ptg_gpio_mode_e;

    typedef enum logic [1:0] {
        ST_IDLE    = 2'h0,
        ST_EXPOSE  = 2'h1,
        ST_IRQ     = 2'h3,
        ST_ADVANCE = 2'h2
    } ptg_state_e;

    typedef struct packed {
        logic [CNT_W-1:0] duty;
        logic [CNT_W-1:0] period;
    } ptg_pwm_cfg_s;

endpackage : ptg_pkg

/* testbench/pattern_trigger_gpio_pins_tb.sv */
`timescale 1ns/100ps
module pattern_trigger_gpio_pins_tb;
    typedef struct packed {
        logic        w;
        logic [7:0]  a;
        logic [31:0] d;
        logic [31:0] q;
        logic        e;
    } ptg_row_s;
    logic        sys_clk = 1'h0;
    logic        rst_b = 1'h0;
    logic [7:0]  paddr = 8'h0;
    logic        psel = 1'h0;
    logic        penable = 1'h0;
    logic        pwrite = 1'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        adv_req = 1'h0;
    logic        ss_req = 1'h0;
    logic        role = 1'h1;
    logic [8:0]  ext_lvl = 9'h0AA;
    logic        adv, ss, exp_o, first_o, irq_o, loop_i, split_o;
    logic [8:0]  gin, gout, goe;
    logic [31:0] rd;
    logic        er;
    int          failures = 0;
    int          n_tests = 0;
    int          cyc = 0;
    int          n;
    ptg_row_s    rows [14] = '{
        '{1'h0, ptg_pkg::REG_CTRL, 32'h0, ptg_pkg::CTRL_RST, 1'h0},
        '{1'h0, ptg_pkg::REG_SEQ, 32'h0, ptg_pkg::SEQ_RST, 1'h0},
        '{1'h0, ptg_pkg::REG_GPIO_MODE, 32'h0, 32'h0, 1'h0},
        '{1'h0, ptg_pkg::REG_STATUS, 32'h0, 32'h2, 1'h0},
        '{1'h1, ptg_pkg::REG_STATUS, 32'hFFFF_FFFF, 32'h0, 1'h0},
        '{1'h0, ptg_pkg::REG_STATUS, 32'h0, 32'h2, 1'h0},
        '{1'h1, 8'h2C, 32'h0010_0020, 32'h0, 1'h0},
        '{1'h0, 8'h2C, 32'h0, 32'h0010_0020, 1'h0},
        '{1'h1, ptg_pkg::REG_PWM_SEL, 32'hF, 32'h0, 1'h0},
        '{1'h0, ptg_pkg::REG_PWM_SEL, 32'h0, 32'hF, 1'h0},
        '{1'h1, 8'h40, 32'h5, 32'h0, 1'h1},
        '{1'h0, 8'h40, 32'h0, 32'h0, 1'h1},
        '{1'h0, ptg_pkg::REG_CMD, 32'h0, 32'h0, 1'h0},
        '{1'h1, ptg_pkg::REG_PWM_SEL, 32'h0, 32'h0, 1'h0}};

    ptg_pins u_dut (.sys_clk(sys_clk), .rst_b(rst_b), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pattern_advance_in(adv),
        .pattern_start_stop_in(ss), .exposure_active_out(exp_o),
        .first_pattern_out(first_o), .seq_irq_loop_out(irq_o), .seq_irq_loop_in(loop_i),
        .split_data_cfg_out(split_o), .ctrl_role_in(role), .gpio_in(gin),
        .gpio_out(gout), .gpio_oe(goe));
    ptg_trig_peer u_peer (.sys_clk(sys_clk), .adv_req(adv_req), .ss_req(ss_req),
        .ext_lvl(ext_lvl), .seq_irq_loop_out(irq_o), .gpio_out(gout), .gpio_oe(goe),
        .pattern_advance_in(adv), .pattern_start_stop_in(ss), .seq_irq_loop_in(loop_i),
        .gpio_in(gin));

    initial forever #2.5 sys_clk = ~sys_clk;

    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : stop_test

    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            failures++;
            stop_test();
        end
    end

    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        n_tests++;
        if (got !== ex) begin
            $display("wrong value %s expected %h seen %h", nm, ex, got);
            failures++;
        end
    endtask : chk

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge sys_clk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'h1;
        k = 0;
        do begin
            @(posedge sys_clk);
            k++;
        end while (pready !== 1'h1 && k < 50);
        rd = prdata;
        er = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask : apb

    // counts edges until the exposure output shows the wanted level
    task automatic wait_exp(input logic lv, input int lim);
        n = 0;
        while (exp_o !== lv && n < lim) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
    endtask : wait_exp

    // advance edges only count once the returned interrupt has moved the sequencer on,
    // and the task returns while the new exposure still stands
    task automatic pulse_adv;
        repeat (40) if (irq_o === 1'h1) begin
            @(posedge sys_clk);
            #1;
        end
        @(posedge sys_clk);
        adv_req <= 1'h1;
        repeat (6) @(posedge sys_clk);
        adv_req <= 1'h0;
    endtask : pulse_adv

    initial begin
        repeat (12) @(posedge sys_clk);
        rst_b <= 1'h1;
        #1;
        chk("reset split", 32'h1, {31'h0, split_o});
        chk("reset oe", 32'h0, {23'h0, goe});
        repeat (8) @(posedge sys_clk);
        foreach (rows[i]) begin
            apb(rows[i].w, rows[i].a, rows[i].d);
            if (!rows[i].w) chk("rdata", rows[i].q, rd);
            chk("pslverr", {31'h0, rows[i].e}, {31'h0, er});
        end
        $display("test done: register table");
        apb(1'h1, ptg_pkg::REG_GPIO_MODE, 32'h0000_0139);
        apb(1'h1, ptg_pkg::REG_GPIO_OUT, 32'h0002_0013);
        repeat (8) @(posedge sys_clk);
        #1;
        chk("gpio_oe", 32'h17, {23'h0, goe});
        chk("gpio_out", 32'h13, {23'h0, gout});
        apb(1'h0, ptg_pkg::REG_GPIO_IN, 32'h0);
        chk("gpio_in", 32'hBB, rd);
        $display("test done: gpio modes");
        apb(1'h1, ptg_pkg::REG_CTRL, 32'h5);
        apb(1'h1, ptg_pkg::REG_SEQ, 32'h0008_0002);
        @(posedge sys_clk);
        ss_req <= 1'h1;
        wait_exp(1'h1, 40);
        chk("start", 32'h1, {31'h0, exp_o});
        chk("first", 32'h1, {31'h0, first_o});
        wait_exp(1'h0, 40);
        chk("exposure len", 32'h8, n);
        chk("irq out", 32'h1, {31'h0, irq_o});
        pulse_adv();
        wait_exp(1'h1, 40);
        chk("advance", 32'h1, {31'h0, exp_o});
        chk("not first", 32'h0, {31'h0, first_o});
        wait_exp(1'h0, 40);
        pulse_adv();
        wait_exp(1'h1, 40);
        chk("wrap first", 32'h1, {31'h0, first_o});
        wait_exp(1'h0, 40);
        @(posedge sys_clk);
        ss_req <= 1'h0;
        repeat (15) @(posedge sys_clk);
        pulse_adv();
        wait_exp(1'h1, 30);
        chk("halted", 32'd30, n);
        apb(1'h1, ptg_pkg::REG_CMD, 32'h1);
        wait_exp(1'h1, 40);
        chk("sw start", 32'h1, {31'h0, exp_o});
        wait_exp(1'h0, 40);
        apb(1'h1, ptg_pkg::REG_CMD, 32'h2);
        repeat (15) @(posedge sys_clk);
        apb(1'h0, ptg_pkg::REG_STATUS, 32'h0);
        chk("sw stop", 32'h0, rd & 32'h1);
        $display("test done: pattern sequence");
        apb(1'h1, ptg_pkg::REG_CTRL, 32'h0);
        apb(1'h1, ptg_pkg::REG_CMD, 32'h1);
        wait_exp(1'h1, 30);
        chk("no video mode", 32'd30, n);
        chk("split off", 32'h0, {31'h0, split_o});
        apb(1'h1, ptg_pkg::REG_CTRL, 32'h4);
        role <= 1'h0;
        repeat (12) @(posedge sys_clk);
        #1;
        chk("secondary split", 32'h0, {31'h0, split_o});
        chk("secondary oe", 32'h0, {23'h0, goe});
        apb(1'h0, ptg_pkg::REG_STATUS, 32'h0);
        chk("role bit", 32'h0, rd & 32'h2);
        role <= 1'h1;
        repeat (12) @(posedge sys_clk);
        #1;
        chk("primary split", 32'h1, {31'h0, split_o});
        chk("primary oe", 32'h17, {23'h0, goe});
        $display("test done: controller role");
        apb(1'h1, ptg_pkg::REG_PWM_CFG0, 32'h0002_0003);
        apb(1'h1, ptg_pkg::REG_PWM_SEL, 32'h1);
        repeat (4) @(posedge sys_clk);
        n = 0;
        repeat (8) begin
            @(posedge sys_clk);
            #1;
            if (gout[0] === 1'h1) n++;
        end
        chk("pwm high count", 32'd4, n);
        $display("test done: pwm output");
        stop_test();
    end
endmodule : pattern_trigger_gpio_pins_tb

/* testbench/ptg_pins_asserts.sv */
`timescale 1ns/100ps
module ptg_pins_asserts (
    // clock and reset
    input wire logic                         sys_clk,
    input wire logic                         rst_b,
    // watched pins
    input wire logic                         exposure_active_out,
    input wire logic                         first_pattern_out,
    input wire logic                         seq_irq_loop_out,
    input wire logic                         split_data_cfg_out,
    input wire logic                         ctrl_role_in,
    input wire logic [ptg_pkg::NUM_GPIO-1:0] gpio_out,
    input wire logic [ptg_pkg::NUM_GPIO-1:0] gpio_oe
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    chk_split_reset: assert property ($rose(rst_b) |-> split_data_cfg_out)
        else $error("split output low out of reset");
    chk_oe_reset: assert property ($rose(rst_b) |-> gpio_oe == '0)
        else $error("gpio pin driven out of reset");
    chk_trig_reset: assert property ($rose(rst_b) |-> !exposure_active_out
        && !first_pattern_out && !seq_irq_loop_out) else $error("trigger out set at reset");
    chk_first_in_exp: assert property (first_pattern_out |-> exposure_active_out)
        else $error("first pattern flag outside exposure");
    chk_first_rise: assert property ($rose(first_pattern_out) |-> $rose(exposure_active_out))
        else $error("first pattern flag not at exposure start");
    chk_irq_after_exp: assert property ($fell(exposure_active_out) |-> ##[0:1] seq_irq_loop_out)
        else $error("no sequencing interrupt after exposure");
    chk_irq_no_exp: assert property (seq_irq_loop_out |-> !exposure_active_out)
        else $error("exposure during interrupt");
    // sync of the role pin takes a few edges, so eight low samples are waited for
    chk_secondary_quiet: assert property (!ctrl_role_in [*8] |-> ##1 (gpio_oe == '0
        && gpio_out == '0 && !split_data_cfg_out && !exposure_active_out))
        else $error("pins active as secondary");
endmodule : ptg_pins_asserts

bind ptg_pins ptg_pins_asserts u_chk (
    .sys_clk             (sys_clk),
    .rst_b               (rst_b),
    .exposure_active_out (exposure_active_out),
    .first_pattern_out   (first_pattern_out),
    .seq_irq_loop_out    (seq_irq_loop_out),
    .split_data_cfg_out  (split_data_cfg_out),
    .ctrl_role_in        (ctrl_role_in),
    .gpio_out            (gpio_out),
    .gpio_oe             (gpio_oe)
);

/* testbench/ptg_trig_peer.sv */
`timescale 1ns/100ps
module ptg_trig_peer (
    // clock
    input  wire logic                         sys_clk,
    // bench requests
    input  wire logic                         adv_req,
    input  wire logic                         ss_req,
    input  wire logic [ptg_pkg::NUM_GPIO-1:0] ext_lvl,
    // device side
    input  wire logic                         seq_irq_loop_out,
    input  wire logic [ptg_pkg::NUM_GPIO-1:0] gpio_out,
    input  wire logic [ptg_pkg::NUM_GPIO-1:0] gpio_oe,
    output logic                              pattern_advance_in,
    output logic                              pattern_start_stop_in,
    output logic                              seq_irq_loop_in,
    output logic [ptg_pkg::NUM_GPIO-1:0]      gpio_in
);
    logic [1:0] loop_dly = 2'h0;
    // board delay on the loop wire, so a same-cycle return is never assumed
    always @(posedge sys_clk) begin
        loop_dly <= {loop_dly[0], seq_irq_loop_out};
    end
    assign seq_irq_loop_in = loop_dly[1];
    // triggers move half a cycle off the device clock, as an async source would
    always @(negedge sys_clk) begin
        pattern_advance_in <= adv_req;
        pattern_start_stop_in <= ss_req;
    end
    // undriven pins show the bench level, standing in for the pull-ups
    assign gpio_in = (gpio_oe & gpio_out) | (~gpio_oe & ext_lvl);
endmodule : ptg_trig_peer
